// ==== hw/sdp_dev.sv ====
// Purpose: Device-side pin logic of a four-bank 32-bit synchronous DRAM.
// Assumes: The link clock is sampled by clk; a small array stands in
//   for the cell array, indexed by bank and column.
// Notes: Timing checks of the memory core are not modelled.
`timescale 1ns/10ps
// Overview of operation
// - All inputs, except gate in power-down, are sampled only on rising edges of the link clock.
// - Burst column counter and output registers advance on link edges.
// - Gate low stops the clock: power-down, self refresh or suspend.
// - Gate is synchronous, but seen asynchronously in power-down modes.
// - Input buffers, clock included, are disabled in power-down modes.
// - Commands decode only with select low; select high ignores them.
// - Bursts in progress and lane masks keep working while select high.
// - Select, row, column and write strobes together encode each command.
// - Write data of a lane with its mask high is not stored.
// - Read lane mask high floats that lane two cycles later.
// - Mask bit n governs data bits 8n+7 down to 8n.
// - Bank bits choose the bank for activate, read, write, precharge.
// - Activate takes the row; read or write takes column from bits 7..0.
// - Bit ten on read or write requests auto precharge after the burst.
// - Precharge with bit ten high closes all banks, else the chosen bank.
// - Load mode register stores the address inputs as the op-code.
// - Data moves over a shared 32-bit two-way bus.
// - Burst lengths of 1, 2, 4, 8 or a full page, with terminate.
// - Auto precharge closes the open row once the burst runs out; a terminate leaves it open.
module sdp_dev (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic gate,
  input wire sdp_pkg::sdp_cmd_s pins,
  input wire logic [sdp_pkg::DQ_W-1:0] dq_in,
  output logic [sdp_pkg::DQ_W-1:0] dq_out,
  output logic [sdp_pkg::LANES-1:0] dq_oe_n,
  output logic [2:0] pwr_state,
  output logic [3:0] bank_open
);
  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers; only the second stage is read.
  logic [2:0] lclk_s1_reg, lclk_s2_reg, lclk_prev_reg;
  logic gate_s1_reg, gate_s2_reg;
  sdp_pkg::sdp_cmd_s pin_s1_reg, pin_s2_reg;
  logic [sdp_pkg::DQ_W-1:0] dq_s1_reg, dq_s2_reg;
  logic rise;

  always_ff @(posedge clk) begin
    if (rst) begin
      lclk_s1_reg <= 3'h0;
      lclk_s2_reg <= 3'h0;
      lclk_prev_reg <= 3'h0;
      gate_s1_reg <= 1'h0;
      gate_s2_reg <= 1'h0;
      pin_s1_reg <= '1;
      pin_s2_reg <= '1;
      dq_s1_reg <= '0;
      dq_s2_reg <= '0;
    end else if (ce) begin
      lclk_s1_reg <= {2'h0, link_clk};
      lclk_s2_reg <= lclk_s1_reg;
      lclk_prev_reg <= lclk_s2_reg;
      gate_s1_reg <= gate;
      gate_s2_reg <= gate_s1_reg;
      pin_s1_reg <= pins;
      pin_s2_reg <= pin_s1_reg;
      dq_s1_reg <= dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // Sampling happens only on a rising link clock edge.
  assign rise = lclk_s2_reg[0] & ~lclk_prev_reg[0];

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] burst_len(input logic [2:0] code);
    case (code)
      sdp_pkg::BL_1: burst_len = 9'h001;
      sdp_pkg::BL_2: burst_len = 9'h002;
      sdp_pkg::BL_4: burst_len = 9'h004;
      sdp_pkg::BL_8: burst_len = 9'h008;
      default: burst_len = sdp_pkg::LEN_PAGE;
    endcase
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
      input logic [31:0] new_w, input logic [3:0] mask);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < sdp_pkg::LANES; i++) begin
      if (!mask[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    lane_merge = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Command, bank, burst and power state.
  logic [31:0] mem [0:(1<<sdp_pkg::DEPTH_W)-1];
  logic [sdp_pkg::ADDR_W-1:0] mode_reg, mode_next;
  logic [3:0] open_reg, open_next;
  logic [sdp_pkg::ROW_W-1:0] row_reg [0:3];
  logic [sdp_pkg::ROW_W-1:0] row_next [0:3];
  logic rd_reg, rd_next, wr_reg, wr_next, ap_reg, ap_next;
  logic [1:0] bb_reg, bb_next;
  logic [sdp_pkg::COL_W-1:0] col_reg, col_next;
  logic [8:0] left_reg, left_next;
  sdp_pkg::sdp_pwr_e pwr_reg, pwr_next;
  logic [31:0] rdat_p0_reg, rdat_p0_next;
  logic rv_p0_reg, rv_p0_next;
  logic [3:0] msk_p0_reg, msk_p1_reg, msk_p0_next, msk_p1_next;
  logic [31:0] dq_out_next;
  logic [3:0] oe_n_next;
  logic we;
  logic [sdp_pkg::DEPTH_W-1:0] waddr;
  logic [31:0] wdata;
  logic [2:0] cmd;
  logic tick, burst_on;

  always_comb begin
    mode_next = mode_reg;
    open_next = open_reg;
    for (int b = 0; b < 4; b++) begin
      row_next[b] = row_reg[b];
    end
    rd_next = rd_reg;
    wr_next = wr_reg;
    ap_next = ap_reg;
    bb_next = bb_reg;
    col_next = col_reg;
    left_next = left_reg;
    pwr_next = pwr_reg;
    rdat_p0_next = rdat_p0_reg;
    rv_p0_next = rv_p0_reg;
    msk_p0_next = msk_p0_reg;
    msk_p1_next = msk_p1_reg;
    dq_out_next = dq_out;
    oe_n_next = dq_oe_n;
    we = 1'h0;
    waddr = {bb_reg, col_reg};
    wdata = '0;
    cmd = {pin_s2_reg.row_n, pin_s2_reg.col_n, pin_s2_reg.wr_n};
    burst_on = rd_reg | wr_reg;
    // In a low-power mode the clock buffer is off: no tick at all.
    tick = rise & gate_s2_reg & (pwr_reg == sdp_pkg::SDP_ST_RUN);
    // Leaving power-down follows the gate level alone, without a clock
    // edge, so the controller need not wait for one.
    if (pwr_reg != sdp_pkg::SDP_ST_RUN && gate_s2_reg) begin
      pwr_next = sdp_pkg::SDP_ST_RUN;
    end else if (rise && !gate_s2_reg && pwr_reg == sdp_pkg::SDP_ST_RUN) begin
      if (burst_on) begin
        pwr_next = sdp_pkg::SDP_ST_SUSP;
      end else if (open_reg != 4'h0) begin
        pwr_next = sdp_pkg::SDP_ST_APD;
      end else if (!pin_s2_reg.sel_n && cmd == sdp_pkg::SDP_CMD_REF) begin
        pwr_next = sdp_pkg::SDP_ST_SELF;
      end else begin
        pwr_next = sdp_pkg::SDP_ST_PPD;
      end
    end
    if (tick) begin
      // Mask pipeline gives the two-cycle read float.
      msk_p0_next = pin_s2_reg.mask;
      msk_p1_next = msk_p0_reg;
      rv_p0_next = rd_reg;
      rdat_p0_next = mem[{bb_reg, col_reg}];
      dq_out_next = rdat_p0_reg;
      oe_n_next = ~({4{rv_p0_reg}} & ~msk_p1_reg);
      if (burst_on) begin
        if (wr_reg) begin
          we = 1'h1;
          wdata = lane_merge(mem[{bb_reg, col_reg}], dq_s2_reg,
                             pin_s2_reg.mask);
        end
        col_next = col_reg + 8'h01;
        left_next = left_reg - 9'h001;
        if (left_reg == 9'h001) begin
          rd_next = 1'h0;
          wr_next = 1'h0;
          if (ap_reg) begin
            open_next[bb_reg] = 1'h0;
          end
        end
      end
      if (!pin_s2_reg.sel_n) begin
        case (cmd)
          sdp_pkg::SDP_CMD_ACT: begin
            open_next[pin_s2_reg.bank] = 1'h1;
            row_next[pin_s2_reg.bank] =
              pin_s2_reg.addr[sdp_pkg::ROW_W-1:0];
          end
          sdp_pkg::SDP_CMD_RD, sdp_pkg::SDP_CMD_WR: begin
            rd_next = (cmd == sdp_pkg::SDP_CMD_RD);
            wr_next = (cmd == sdp_pkg::SDP_CMD_WR);
            bb_next = pin_s2_reg.bank;
            col_next = pin_s2_reg.addr[sdp_pkg::COL_W-1:0];
            ap_next = pin_s2_reg.addr[sdp_pkg::SCOPE_BIT];
            left_next = burst_len(
              mode_reg[sdp_pkg::BL_MSB:sdp_pkg::BL_LSB]);
          end
          sdp_pkg::SDP_CMD_BST: begin
            rd_next = 1'h0;
            wr_next = 1'h0;
          end
          sdp_pkg::SDP_CMD_PRE: begin
            if (pin_s2_reg.addr[sdp_pkg::SCOPE_BIT]) begin
              open_next = 4'h0;
            end else begin
              open_next[pin_s2_reg.bank] = 1'h0;
            end
          end
          sdp_pkg::SDP_CMD_LMR: begin
            mode_next = pin_s2_reg.addr;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // The array has no reset; it holds data, not control.
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= sdp_pkg::MODE_RST;
      open_reg <= 4'h0;
      for (int b = 0; b < 4; b++) begin
        row_reg[b] <= '0;
      end
      rd_reg <= 1'h0;
      wr_reg <= 1'h0;
      ap_reg <= 1'h0;
      bb_reg <= 2'h0;
      col_reg <= 8'h00;
      left_reg <= 9'h000;
      pwr_reg <= sdp_pkg::SDP_ST_RUN;
      rdat_p0_reg <= '0;
      rv_p0_reg <= 1'h0;
      msk_p0_reg <= 4'h0;
      msk_p1_reg <= 4'h0;
      dq_out <= '0;
      dq_oe_n <= 4'hF;
      pwr_state <= 3'h0;
      bank_open <= 4'h0;
    end else if (ce) begin
      mode_reg <= mode_next;
      open_reg <= open_next;
      for (int b = 0; b < 4; b++) begin
        row_reg[b] <= row_next[b];
      end
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      ap_reg <= ap_next;
      bb_reg <= bb_next;
      col_reg <= col_next;
      left_reg <= left_next;
      pwr_reg <= pwr_next;
      rdat_p0_reg <= rdat_p0_next;
      rv_p0_reg <= rv_p0_next;
      msk_p0_reg <= msk_p0_next;
      msk_p1_reg <= msk_p1_next;
      dq_out <= dq_out_next;
      dq_oe_n <= oe_n_next;
      pwr_state <= pwr_next;
      bank_open <= open_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // A frozen core must not move, whatever the pins and link clock do.
  property p_no_tick_in_pd;
    @(posedge clk) disable iff (rst)
      (pwr_reg != sdp_pkg::SDP_ST_RUN) |=>
        $stable(open_reg) && $stable(col_reg) && $stable(dq_oe_n) &&
        $stable(mode_reg);
  endproperty
  a_no_tick_in_pd: assert property (p_no_tick_in_pd)
    else $error("Clock ticked in a low-power mode.");

  // Bursts may still run with select high, so only idle cycles count.
  property p_select_ignored;
    @(posedge clk) disable iff (rst)
      (ce && tick && pin_s2_reg.sel_n && !burst_on) |=>
        $stable(open_reg) && $stable(mode_reg) && !rd_reg && !wr_reg;
  endproperty
  a_select_ignored: assert property (p_select_ignored)
    else $error("Command decoded with select high.");

  property p_pd_exit;
    @(posedge clk) disable iff (rst)
      (ce && pwr_reg != sdp_pkg::SDP_ST_RUN && gate_s2_reg) |=>
        pwr_reg == sdp_pkg::SDP_ST_RUN;
  endproperty
  a_pd_exit: assert property (p_pd_exit)
    else $error("Power-down did not exit on gate high.");

  property p_suspend;
    @(posedge clk) disable iff (rst)
      (ce && rise && !gate_s2_reg && burst_on &&
       pwr_reg == sdp_pkg::SDP_ST_RUN) |=> pwr_reg == sdp_pkg::SDP_ST_SUSP;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("Burst did not enter clock suspend.");

  property p_lmr;
    @(posedge clk) disable iff (rst)
      (ce && tick && !pin_s2_reg.sel_n && cmd == sdp_pkg::SDP_CMD_LMR) |=>
        mode_reg == $past(pin_s2_reg.addr);
  endproperty
  a_lmr: assert property (p_lmr)
    else $error("Mode register not loaded.");

  property p_pre_all;
    @(posedge clk) disable iff (rst)
      (ce && tick && !pin_s2_reg.sel_n && cmd == sdp_pkg::SDP_CMD_PRE &&
       pin_s2_reg.addr[sdp_pkg::SCOPE_BIT]) |=> open_reg == 4'h0;
  endproperty
  a_pre_all: assert property (p_pre_all)
    else $error("Precharge all left a bank open.");

  property p_act;
    @(posedge clk) disable iff (rst)
      (ce && tick && !pin_s2_reg.sel_n && cmd == sdp_pkg::SDP_CMD_ACT) |=>
        open_reg[$past(pin_s2_reg.bank)];
  endproperty
  a_act: assert property (p_act)
    else $error("Activate did not open the bank.");

  // Enables only move on a tick, so checking there covers every cycle.
  property p_drive_only_read;
    @(posedge clk) disable iff (rst)
      (ce && tick) |=> (dq_oe_n == 4'hF) || $past(rv_p0_reg);
  endproperty
  a_drive_only_read: assert property (p_drive_only_read)
    else $error("Data driven outside a read.");
endmodule

// ==== hw/sdp_pkg.sv ====
// Purpose: Shared constants and types for the SDRAM pin interface block.
// Assumes: Command codes follow the usual select/row/column/write strobes.
// Notes: Mode register field positions cover burst length and latency.
package sdp_pkg;
  localparam int DQ_W = 32;
  localparam int LANES = 4;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 2;
  localparam int COL_W = 8;
  localparam int ROW_W = 11;
  localparam int DEPTH_W = 10;
  localparam int ROWS_STORED = 4;
  localparam int MASK_LAT = 2;
  localparam int SCOPE_BIT = 10;
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam int CL_LSB = 4;
  localparam int CL_MSB = 6;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] CL_DEF = 3'h2;
  localparam logic [ADDR_W-1:0] MODE_RST = 12'h022;
  localparam logic [8:0] LEN_PAGE = 9'h100;

  typedef enum logic [2:0] {
    SDP_CMD_NOP = 3'h7,
    SDP_CMD_ACT = 3'h3,
    SDP_CMD_RD = 3'h5,
    SDP_CMD_WR = 3'h4,
    SDP_CMD_BST = 3'h6,
    SDP_CMD_PRE = 3'h2,
    SDP_CMD_REF = 3'h1,
    SDP_CMD_LMR = 3'h0
  } sdp_cmd_e;

  typedef enum logic [2:0] {
    SDP_ST_RUN = 3'h0,
    SDP_ST_PPD = 3'h1,
    SDP_ST_APD = 3'h2,
    SDP_ST_SUSP = 3'h3,
    SDP_ST_SELF = 3'h4
  } sdp_pwr_e;

  typedef struct packed {
    logic sel_n;
    logic row_n;
    logic col_n;
    logic wr_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] mask;
  } sdp_cmd_s;
endpackage

// ==== verif/sdp_ctl_model.sv ====
// Purpose: Memory controller model driving the pin interface.
// Assumes: Free-running link clock; pins change mid link cycle.
// Notes: Released data lanes show the inverse of the last value.
`timescale 1ns/10ps
module sdp_ctl_model (
  input wire logic clk,
  output logic link_clk,
  output logic gate,
  output sdp_pkg::sdp_cmd_s pins,
  output logic [31:0] dq_drv,
  output int tick
);
  initial begin
    link_clk = 1'b0;
    gate = 1'b1;
    pins = {4'h7, 2'h0, 12'h0, 4'h0};
    dq_drv = 32'h0;
    tick = 0;
    forever #32 link_clk = ~link_clk;
  end

  always @(posedge link_clk) tick <= tick + 1;

  ////////////////////////////////////////////////////////////////////////
  // One link cycle; changing mid-cycle keeps the pins clear of the edge.
  task automatic cyc(input logic [3:0] c, input logic [1:0] b,
      input logic [11:0] a, input logic [3:0] m, input logic [31:0] d,
      input logic w, output int t);
    @(negedge link_clk);
    @(negedge clk);
    pins = {c, b, a, m};
    dq_drv = w ? d : ~dq_drv;
    @(posedge link_clk);
    #1 t = tick;
  endtask

  task automatic set_gate(input logic g);
    @(negedge clk);
    gate = g;
  endtask
endmodule

// ==== verif/sdram_pin_interface_bench.sv ====
// Purpose: Self-checking bench of the pin interface device logic.
// Assumes: Read data appears two link ticks after its command.
// Notes: Unwritten words are never read, so expectations stay known.
`timescale 1ns/10ps
module sdram_pin_interface_bench;
  typedef struct packed {
    logic [31:0] t;
    logic [3:0] oe;
    logic [31:0] d;
  } sdp_note_s;
  localparam logic [3:0] NOP = {1'b0, sdp_pkg::SDP_CMD_NOP};
  localparam logic [3:0] ACT = {1'b0, sdp_pkg::SDP_CMD_ACT};
  localparam logic [3:0] RD = {1'b0, sdp_pkg::SDP_CMD_RD};
  localparam logic [3:0] WR = {1'b0, sdp_pkg::SDP_CMD_WR};
  localparam logic [3:0] PRE = {1'b0, sdp_pkg::SDP_CMD_PRE};
  localparam logic [3:0] REF = {1'b0, sdp_pkg::SDP_CMD_REF};
  localparam logic [3:0] LMR = {1'b0, sdp_pkg::SDP_CMD_LMR};
  localparam logic [3:0] BST = {1'b0, sdp_pkg::SDP_CMD_BST};
  localparam logic [3:0] DSL = {1'b1, sdp_pkg::SDP_CMD_ACT};
  logic clk, rst, ce, link_clk, gate;
  sdp_pkg::sdp_cmd_s pins;
  logic [31:0] dq_drv, dq_in, dq_out;
  logic [3:0] dq_oe_n, bank_open;
  logic [2:0] pwr_state;
  logic [31:0] mem [1024];
  logic [2:0] bls [5];
  sdp_note_s notes[$];
  sdp_note_s n;
  int tick, t, bad_count, checks_done;

  sdp_dev uut (.clk(clk), .rst(rst), .ce(ce), .link_clk(link_clk),
    .gate(gate), .pins(pins), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .pwr_state(pwr_state), .bank_open(bank_open));
  sdp_ctl_model ctl (.clk(clk), .link_clk(link_clk), .gate(gate),
    .pins(pins), .dq_drv(dq_drv), .tick(tick));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // One-clock stalls at random, never two in a row, so each link edge is
  // still taken well inside its own link cycle.
  always @(negedge clk) ce <= rst | !ce | ($urandom % 4 != 0);

  function automatic logic [31:0] lanes(input logic [3:0] m);
    for (int l = 0; l < 4; l++) lanes[8*l+:8] = {8{~m[l]}};
  endfunction

  // The shared bus: a lane the device drives wins over the controller.
  always_comb dq_in = (dq_out & lanes(dq_oe_n)) | (dq_drv & ~lanes(dq_oe_n));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(negedge link_clk) begin
    @(negedge clk);
    if (!rst && dq_oe_n !== 4'hF) begin
      if (notes.size() == 0) begin
        check({60'h0, dq_oe_n}, 64'hF);
      end else begin
        n = notes.pop_front();
        check(tick, n.t);
        check(dq_oe_n, n.oe);
        check(dq_out & lanes(n.oe), n.d);
      end
    end
  end

  task automatic idle(input int k);
    repeat (k) ctl.cyc(NOP, 2'h0, 12'h0, 4'h0, 32'h0, 1'b0, t);
  endtask

  // Odd words of a burst carry the mask, even words none.
  task automatic wr(input logic [1:0] b, input logic [7:0] c, input int k,
      input logic [3:0] m);
    logic [31:0] d;
    logic [9:0] ix;
    logic [3:0] mk;
    ctl.cyc(WR, b, {4'h0, c}, 4'h0, 32'h0, 1'b0, t);
    for (int i = 0; i < k; i++) begin
      d = $urandom;
      ix = {b, c + i[7:0]};
      mk = i[0] ? m : 4'h0;
      ctl.cyc(NOP, b, 12'h0, mk, d, 1'b1, t);
      mem[ix] = (mem[ix] & ~lanes(mk)) | (d & lanes(mk));
    end
  endtask

  task automatic rd(input logic [1:0] b, input logic [7:0] c, input int k,
      input logic [3:0] m, input logic ap, input logic [3:0] rest);
    logic [3:0] mk;
    int t0;
    for (int i = 0; i < k + 2; i++) begin
      mk = (i < k && i[0]) ? m : 4'h0;
      ctl.cyc(i == 0 ? RD : rest, b, {1'b0, ap, 2'h0, c}, mk, 32'h0, 1'b0, t);
      if (i == 0) t0 = t;
      if (i < k && mk != 4'hF) begin
        notes.push_back('{t0 + i + 2, mk, mem[{b, c + i[7:0]}] & lanes(mk)});
      end
    end
  endtask

  task automatic wait_pwr(input logic [2:0] e);
    int k;
    k = 0;
    while (pwr_state !== e && k < 200) begin
      @(negedge clk);
      k++;
    end
    check(pwr_state, e);
    if (k == 200) summarize();
  endtask

  initial begin
    #400000;
    bad_count++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    bls = '{sdp_pkg::BL_1, sdp_pkg::BL_2, sdp_pkg::BL_4, sdp_pkg::BL_8,
      sdp_pkg::BL_PAGE};
    void'($urandom(32'hc8c2));
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    check(dq_oe_n, 4'hF);
    check(dq_out, 32'h0);
    check(pwr_state, 3'h0);
    check(bank_open, 4'h0);
    $display("reset test done");
    ctl.cyc(ACT, 2'h1, 12'h5A5, 4'h0, 32'h0, 1'b0, t);
    ctl.cyc(ACT, 2'h2, 12'h3C3, 4'h0, 32'h0, 1'b0, t);
    idle(3);
    check(bank_open, 4'h6);
    wr(2'h1, 8'h10, 4, 4'h0);
    wr(2'h1, 8'h10, 4, 4'h5);
    rd(2'h1, 8'h10, 4, 4'h6, 1'b0, NOP);
    rd(2'h1, 8'h10, 4, 4'hF, 1'b0, DSL);
    ctl.cyc(DSL, 2'h0, 12'h0, 4'h0, 32'h0, 1'b0, t);
    idle(3);
    check(bank_open, 4'h6);
    $display("mask and select test done");
    for (int i = 0; i < 5; i++) begin
      ctl.cyc(LMR, 2'h0, {9'h004, bls[i]}, 4'h0, 32'h0, 1'b0, t);
      wr(2'h2, 8'h40, i == 4 ? 256 : 1 << i, 4'h0);
      rd(2'h2, 8'h40, i == 4 ? 256 : 1 << i, 4'h3, 1'b0, NOP);
    end
    ctl.cyc(LMR, 2'h0, 12'h022, 4'h0, 32'h0, 1'b0, t);
    rd(2'h2, 8'h40, 1, 4'h0, 1'b0, BST);
    $display("burst length test done");
    rd(2'h2, 8'h40, 4, 4'h0, 1'b1, NOP);
    idle(3);
    check(bank_open, 4'h2);
    ctl.cyc(ACT, 2'h3, 12'h001, 4'h0, 32'h0, 1'b0, t);
    ctl.cyc(PRE, 2'h3, 12'h000, 4'h0, 32'h0, 1'b0, t);
    idle(3);
    check(bank_open, 4'h2);
    ctl.cyc(PRE, 2'h0, 12'h400, 4'h0, 32'h0, 1'b0, t);
    idle(3);
    check(bank_open, 4'h0);
    $display("precharge test done");
    ctl.set_gate(1'b0);
    wait_pwr(3'h1);
    ctl.set_gate(1'b1);
    wait_pwr(3'h0);
    ctl.cyc(ACT, 2'h0, 12'h010, 4'h0, 32'h0, 1'b0, t);
    idle(2);
    ctl.set_gate(1'b0);
    wait_pwr(3'h2);
    ctl.set_gate(1'b1);
    wait_pwr(3'h0);
    ctl.cyc(PRE, 2'h0, 12'h400, 4'h0, 32'h0, 1'b0, t);
    idle(2);
    fork
      ctl.cyc(REF, 2'h0, 12'h0, 4'h0, 32'h0, 1'b0, t);
      begin
        @(negedge link_clk);
        ctl.set_gate(1'b0);
      end
    join
    wait_pwr(3'h4);
    ctl.set_gate(1'b1);
    wait_pwr(3'h0);
    ctl.cyc(LMR, 2'h0, 12'h023, 4'h0, 32'h0, 1'b0, t);
    ctl.cyc(ACT, 2'h0, 12'h010, 4'h0, 32'h0, 1'b0, t);
    ctl.cyc(WR, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0, t);
    ctl.cyc(NOP, 2'h0, 12'h0, 4'h0, $urandom, 1'b1, t);
    ctl.set_gate(1'b0);
    wait_pwr(3'h3);
    ctl.set_gate(1'b1);
    wait_pwr(3'h0);
    idle(10);
    $display("power test done");
    check(notes.size(), 64'h0);
    summarize();
  end
endmodule
